// file: clk_switch_pkg.sv
// Constants and types for the clock source switch block
package clk_switch_pkg;
    // Register addresses on the special-register bus
    localparam logic [15:0] ADDR_TUNE = 16'h0096;
    localparam logic [15:0] ADDR_CTRL = 16'hFFDE;

    // Tuning register fields
    localparam int TUNE_TRIM_MSB = 5;
    localparam int TUNE_CLKOUT_BIT = 6;
    localparam int TUNE_RCFAST_BIT = 7;

    // Clock control register fields
    localparam int CTRL_DBL_BIT = 3;
    localparam int CTRL_XWD_BIT = 4;
    localparam int CTRL_RATE_BIT = 5;
    localparam int CTRL_DONE_BIT = 7;

    // Flash configuration byte fields
    localparam int CFG_DBL_BIT = 7;

    // Reset values of the software-written upper bits and the switch-complete flag
    localparam logic RST_CLKOUT = 1'b0;
    localparam logic RST_RCFAST = 1'b0;
    localparam logic RST_RATE = 1'b0;
    localparam logic RST_XWD = 1'b0;
    localparam logic RST_DONE = 1'b1;

    // Oscillator type codes
    localparam logic [2:0] OSC_EXT = 3'h7;
    localparam logic [2:0] OSC_WDO = 3'h4;
    localparam logic [2:0] OSC_RC = 3'h3;
    localparam logic [2:0] OSC_XLF = 3'h2;
    localparam logic [2:0] OSC_XMF = 3'h1;
    localparam logic [2:0] OSC_XHF = 3'h0;

    // Watchdog clock source codes
    localparam logic [1:0] WDSRC_400K = 2'h0;
    localparam logic [1:0] WDSRC_25K = 2'h1;
    localparam logic [1:0] WDSRC_XTAL = 2'h2;
    localparam logic [1:0] WDSRC_PCLK = 2'h3;

    // Wake-up timing
    localparam int SYS_CLK_MHZ = 40;
    localparam int XTAL_WAKE_TICKS = 1024;
    localparam int SHORT_WAKE_TICKS = 32;
    localparam int XTAL_EXTRA_US = 60;
    localparam int RC_WAKE_US = 200;
    localparam int XTAL_EXTRA_CYCLES = XTAL_EXTRA_US * SYS_CLK_MHZ;
    localparam int RC_WAKE_CYCLES = RC_WAKE_US * SYS_CLK_MHZ;
    localparam int CNT_W = 14;

    // Switch sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAKE = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_SWAP = 4'b1000
    } sw_state_t;
endpackage

// file: clock_source_switch_control.sv
// Clock source selection, on-the-fly switching and wake-up delay control
// Summary of operation
// - Six low tuning bits set RC frequency, loaded from factory value at reset.
// - Clock-output enable drives half CPU clock on crystal output when crystal unused.
// - RC fast-select makes RC the CPU clock source without reset.
// - Watchdog oscillator runs at 400 kHz or 25 kHz.
// - Clock source may switch at run time among four sources.
// - Bit 7 of control register is read-only switch-complete flag.
// - Starting a switch clears the switch-complete flag automatically.
// - Control register writes are ignored while switch-complete flag is 0.
// - Oscillator type and doubler load from flash configuration byte at reset.
// - Oscillator type codes: 111 ext, 100 wdog, 011 RC, 010/001/000 crystals.
// - Doubler bit doubles the RC output used for switching.
// - Crystal-for-watchdog bit picks low-speed crystal as watchdog clock.
// - Rate bit picks 400 kHz or 25 kHz watchdog oscillator when crystal not used.
// - Crystal sources wait 1024 oscillator ticks plus 60 us.
// - RC source waits 200 us before release.
// - Watchdog oscillator or external clock waits 32 oscillator ticks.
// - Reset clears clock-output enable and RC fast-select, loads tuning bits.
// - Larger tuning value lowers RC frequency, smaller raises it.
`timescale 1ns/1ps

module clock_source_switch_control
    import clk_switch_pkg::*;
#(
    parameter int RC_WAKE_CNT = RC_WAKE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Special-register bus
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Flash and factory values caught after reset
    input wire logic [7:0] flash_config_byte_one,
    input wire logic [5:0] factory_trim,
    // Oscillator ticks, one pulse per oscillator period
    input wire logic xtal_tick,
    input wire logic rc_tick,
    input wire logic wdo_tick,
    input wire logic ext_tick,
    input wire logic cpu_tick,
    // Watchdog request for its own oscillator
    input wire logic watchdog_clock_select,
    // Oscillator and clock tree controls
    output logic [5:0] rc_trim,
    output logic rc_doubler_on,
    output logic [2:0] oscillator_clock_source,
    output logic wdo_rate_slow,
    output logic [1:0] watchdog_clock_source,
    output logic clock_output_active,
    // Crystal output pin
    output logic crystal_output_pin_out,
    output logic crystal_output_pin_oe_n
);

    if (RC_WAKE_CNT < 1 || RC_WAKE_CNT >= (1 << CNT_W)) begin : g_rc_wake_range
        $error("RC_WAKE_CNT out of counter range");
    end

    // Register state
    logic [5:0] trim;
    logic clock_output_enable;
    logic rc_fast_select;
    logic [2:0] osc_type;
    logic rc_doubler;
    logic crystal_for_watchdog;
    logic watchdog_rate_select;
    logic switch_complete_flag;
    logic loaded;
    // Switch sequencer state
    sw_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [2:0] pend_src;
    logic pend_dbl;
    logic clkout_q;
    logic wr_tune;
    logic wr_ctrl;
    logic [2:0] target_src;
    logic start;
    logic pend_tick;

    // True for any of the three crystal codes
    function automatic logic is_xtal(input logic [2:0] code);
        return (code == OSC_XLF) || (code == OSC_XMF) || (code == OSC_XHF);
    endfunction

    // Tick of the oscillator a code names
    function automatic logic tick_of(input logic [2:0] code, input logic xt, input logic rc,
                                     input logic wd, input logic ex);
        unique case (code)
            OSC_EXT: return ex;
            OSC_WDO: return wd;
            OSC_RC: return rc;
            default: return xt;
        endcase
    endfunction

    // Bus decode
    assign wr_tune = sfr_wr && (sfr_addr == ADDR_TUNE);
    assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_CTRL);

    // Requested source: fast-select overrides the type field
    assign target_src = rc_fast_select ? OSC_RC : osc_type;
    assign start = loaded && (state == ST_IDLE) &&
                   ((target_src != oscillator_clock_source) || (rc_doubler != rc_doubler_on));
    assign pend_tick = tick_of(pend_src, xtal_tick, rc_tick, wdo_tick, ext_tick);

    // Configuration catch one edge after reset release
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            loaded <= 1'b0;
        end else begin
            loaded <= 1'b1;
        end
    end

    // Tuning register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trim <= '0;
            clock_output_enable <= RST_CLKOUT;
            rc_fast_select <= RST_RCFAST;
        end else if (!loaded) begin
            trim <= factory_trim;
        end else if (wr_tune) begin
            trim <= sfr_wdata[TUNE_TRIM_MSB:0];
            clock_output_enable <= sfr_wdata[TUNE_CLKOUT_BIT];
            rc_fast_select <= sfr_wdata[TUNE_RCFAST_BIT];
        end
    end

    // Clock control register, writes refused while a switch runs
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osc_type <= OSC_XHF;
            rc_doubler <= 1'b0;
            crystal_for_watchdog <= RST_XWD;
            watchdog_rate_select <= RST_RATE;
        end else if (!loaded) begin
            osc_type <= flash_config_byte_one[2:0];
            rc_doubler <= flash_config_byte_one[CFG_DBL_BIT];
        end else if (wr_ctrl && switch_complete_flag) begin
            osc_type <= sfr_wdata[2:0];
            rc_doubler <= sfr_wdata[CTRL_DBL_BIT];
            crystal_for_watchdog <= sfr_wdata[CTRL_XWD_BIT];
            watchdog_rate_select <= sfr_wdata[CTRL_RATE_BIT];
        end
    end

    // Switch-complete flag
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            switch_complete_flag <= RST_DONE;
        end else if (start) begin
            switch_complete_flag <= 1'b0;
        end else if (state == ST_SWAP) begin
            switch_complete_flag <= 1'b1;
        end
    end

    // Wake-up sequencer: crystals count source ticks then wall time, RC wall time only, others source ticks only, then hand over
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cnt <= '0;
            pend_src <= OSC_XHF;
            pend_dbl <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    cnt <= '0;
                    if (start) begin
                        pend_src <= target_src;
                        pend_dbl <= rc_doubler;
                        if (target_src == OSC_RC) begin
                            state <= ST_HOLD;
                        end else begin
                            state <= ST_WAKE;
                        end
                    end
                end
                ST_WAKE: begin
                    if (pend_tick) begin
                        if (is_xtal(pend_src) && cnt == CNT_W'(XTAL_WAKE_TICKS - 1)) begin
                            cnt <= '0;
                            state <= ST_HOLD;
                        end else if (!is_xtal(pend_src) && cnt == CNT_W'(SHORT_WAKE_TICKS - 1)) begin
                            cnt <= '0;
                            state <= ST_SWAP;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                end
                ST_HOLD: begin
                    if ((pend_src == OSC_RC && cnt == CNT_W'(RC_WAKE_CNT - 1)) ||
                        (pend_src != OSC_RC && cnt == CNT_W'(XTAL_EXTRA_CYCLES - 1))) begin
                        cnt <= '0;
                        state <= ST_SWAP;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_SWAP: begin
                    cnt <= '0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Active clock tree selection, loaded from the config byte after reset, then moved only at the handover cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oscillator_clock_source <= OSC_XHF;
            rc_doubler_on <= 1'b0;
        end else if (!loaded) begin
            oscillator_clock_source <= flash_config_byte_one[2:0];
            rc_doubler_on <= flash_config_byte_one[CFG_DBL_BIT];
        end else if (state == ST_SWAP) begin
            oscillator_clock_source <= pend_src;
            rc_doubler_on <= pend_dbl;
        end
    end

    // Oscillator and watchdog controls; higher trim lowers RC frequency
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rc_trim <= '0;
            wdo_rate_slow <= 1'b0;
            watchdog_clock_source <= WDSRC_PCLK;
        end else begin
            rc_trim <= trim;
            wdo_rate_slow <= watchdog_rate_select;
            if (crystal_for_watchdog) begin
                watchdog_clock_source <= WDSRC_XTAL;
            end else if (watchdog_clock_select) begin
                watchdog_clock_source <= watchdog_rate_select ? WDSRC_25K : WDSRC_400K;
            end else begin
                watchdog_clock_source <= WDSRC_PCLK;
            end
        end
    end

    // Clock output: toggle per CPU clock gives half frequency
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clkout_q <= 1'b0;
            clock_output_active <= 1'b0;
        end else begin
            clock_output_active <= clock_output_enable && !is_xtal(oscillator_clock_source) &&
                                   (state == ST_IDLE || !is_xtal(pend_src)) && !crystal_for_watchdog;
            if (!clock_output_active) begin
                clkout_q <= 1'b0;
            end else if (cpu_tick) begin
                clkout_q <= !clkout_q;
            end
        end
    end
    assign crystal_output_pin_out = clkout_q;
    assign crystal_output_pin_oe_n = !clock_output_active;

    // Read data, registered on the read strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= '0;
        end else if (sfr_rd) begin
            if (sfr_addr == ADDR_TUNE) begin
                sfr_rdata <= {rc_fast_select, clock_output_enable, trim};
            end else if (sfr_addr == ADDR_CTRL) begin
                sfr_rdata <= {switch_complete_flag, 1'b0, watchdog_rate_select,
                              crystal_for_watchdog, rc_doubler, osc_type};
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    // Checks
    sequence s_start;
        state == ST_IDLE && start;
    endsequence
    sequence s_swap;
        state == ST_SWAP;
    endsequence

    a_trim_load: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(loaded) |=> rc_trim == $past(factory_trim, 2))
        else $error("tuning bits not loaded from factory value");

    a_ctrl_load: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(loaded) |-> osc_type == $past(flash_config_byte_one[2:0])
                          && rc_doubler == $past(flash_config_byte_one[CFG_DBL_BIT]))
        else $error("control register not loaded from config byte");

    a_flag_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_start |=> !switch_complete_flag)
        else $error("flag not cleared at switch start");

    a_write_refused: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_ctrl && !switch_complete_flag |=> $stable(osc_type) && $stable(rc_doubler)
                                             && $stable(watchdog_rate_select))
        else $error("control write accepted during switch");

    a_swap_done: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_swap |=> switch_complete_flag && oscillator_clock_source == $past(pend_src)
                   && rc_doubler_on == $past(pend_dbl))
        else $error("handover did not complete");

    a_short_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
        state == ST_WAKE && !is_xtal(pend_src) && pend_tick && cnt == CNT_W'(SHORT_WAKE_TICKS - 1)
        |=> s_swap)
        else $error("short wake-up not 32 ticks");

    a_flag_low_busy: assert property (@(posedge clk_sys) disable iff (!nrst)
        state == ST_WAKE || state == ST_HOLD |-> !switch_complete_flag)
        else $error("flag high during switch");

    a_wd_rate: assert property (@(posedge clk_sys) disable iff (!nrst)
        watchdog_clock_select && !crystal_for_watchdog && $stable(watchdog_rate_select)
        |=> watchdog_clock_source == ($past(watchdog_rate_select) ? WDSRC_25K : WDSRC_400K))
        else $error("watchdog rate selection wrong");

    a_clkout_toggle: assert property (@(posedge clk_sys) disable iff (!nrst)
        clock_output_active && cpu_tick |=> clkout_q != $past(clkout_q))
        else $error("clock output did not toggle");

    a_rc_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        state == ST_HOLD |-> cnt < CNT_W'(RC_WAKE_CNT) || pend_src != OSC_RC)
        else $error("RC wake-up overran");

endmodule

// file: tb_clock_source_switch_control.sv
// Self-checking testbench for the clock source switch block
`timescale 1ns/1ps

module tb_clock_source_switch_control;
    import clk_switch_pkg::*;

    localparam int RC_CNT = 20;

    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] sfr_addr = 16'h0000;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [7:0] flash_config_byte_one = 8'h8B;
    logic [5:0] factory_trim = 6'h2A;
    logic xtal_tick = 1'b0;
    logic rc_tick = 1'b0;
    logic wdo_tick = 1'b0;
    logic ext_tick = 1'b0;
    logic cpu_tick = 1'b0;
    logic watchdog_clock_select = 1'b0;
    logic [5:0] rc_trim;
    logic rc_doubler_on;
    logic [2:0] oscillator_clock_source;
    logic wdo_rate_slow;
    logic [1:0] watchdog_clock_source;
    logic clock_output_active;
    logic crystal_output_pin_out;
    logic crystal_output_pin_oe_n;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] rd;
    logic [2:0] codes [5] = '{OSC_EXT, OSC_XLF, OSC_XMF, OSC_XHF, OSC_WDO};
    int periods [5] = '{2, 2, 2, 2, 5};

    clock_source_switch_control #(.RC_WAKE_CNT(RC_CNT)) clock_source_switch_control_i (
        .clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_config_byte_one(flash_config_byte_one),
        .factory_trim(factory_trim), .xtal_tick(xtal_tick), .rc_tick(rc_tick), .wdo_tick(wdo_tick),
        .ext_tick(ext_tick), .cpu_tick(cpu_tick), .watchdog_clock_select(watchdog_clock_select),
        .rc_trim(rc_trim), .rc_doubler_on(rc_doubler_on), .oscillator_clock_source(oscillator_clock_source),
        .wdo_rate_slow(wdo_rate_slow), .watchdog_clock_source(watchdog_clock_source),
        .clock_output_active(clock_output_active), .crystal_output_pin_out(crystal_output_pin_out),
        .crystal_output_pin_oe_n(crystal_output_pin_oe_n)
    );

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    // Oscillator ticks at fixed ratios: crystal/ext 2, RC 3, watchdog 5, CPU 4 cycles
    always @(negedge clk_sys) begin
        cyc <= cyc + 1;
        xtal_tick <= (cyc % 2) == 0;
        ext_tick <= (cyc % 2) == 1;
        rc_tick <= (cyc % 3) == 0;
        wdo_tick <= (cyc % 5) == 0;
        cpu_tick <= (cyc % 4) == 0;
    end

    // Final verdict and end of run
    task automatic conclude();
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Compare one value and report a mismatch
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe, launched on the falling edge
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask

    // One-cycle read strobe; data is registered at the rising edge in between
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask

    // Poll the flag until set, bounded; returns cycles since t0
    task automatic wait_done(input int t0, output int el);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 4000 && v[CTRL_DONE_BIT] !== 1'b1; i++) begin
            rd_reg(ADDR_CTRL, v);
        end
        el = cyc - t0;
        chk({7'h00, v[CTRL_DONE_BIT]}, 8'h01, "flag set after switch");
    endtask

    // Start a switch, check clearing, refusal and the wake-up span
    task automatic do_switch(input logic [15:0] a, input logic [7:0] d, input int min_cyc,
                             input logic [2:0] exp_src);
        int t0;
        int el;
        logic [7:0] v;
        logic [7:0] v0;
        wr_reg(a, d);
        t0 = cyc;
        rd_reg(ADDR_CTRL, v);
        chk({7'h00, v[CTRL_DONE_BIT]}, 8'h00, "flag clear during switch");
        v0 = v;
        wr_reg(ADDR_CTRL, v ^ 8'h01);
        wait_done(t0, el);
        checks++;
        if (el < min_cyc || el > min_cyc + min_cyc / 8 + 24) begin
            bad_count++;
            $display("BAD %0t wake-up span %0d cycles, minimum %0d", $time, el, min_cyc);
        end
        chk({5'h00, oscillator_clock_source}, {5'h00, exp_src}, "running source");
        rd_reg(ADDR_CTRL, v);
        chk(v & 8'h07, (a == ADDR_CTRL) ? (d & 8'h07) : (v0 & 8'h07), "refused write kept type");
    endtask

    // Cut a hung run short
    initial begin
        #(60000 * 25);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    // Main sequence
    initial begin
        int n;
        logic last;
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rd_reg(ADDR_TUNE, rd);
        chk(rd, 8'h2A, "tune reset value");
        chk({2'h0, rc_trim}, 8'h2A, "trim output after reset");
        rd_reg(ADDR_CTRL, rd);
        chk(rd, 8'h8B, "control reset value");
        chk({5'h00, oscillator_clock_source}, {5'h00, OSC_RC}, "source after reset");
        chk({7'h00, rc_doubler_on}, 8'h01, "doubler after reset");
        chk({7'h00, clock_output_active}, 8'h00, "clock output off at reset");
        chk({7'h00, crystal_output_pin_oe_n}, 8'h01, "pin released at reset");
        wr_reg(ADDR_TUNE, 8'h6A);
        repeat (2) @(negedge clk_sys);
        chk({7'h00, clock_output_active}, 8'h01, "clock output from reset source");
        wr_reg(ADDR_TUNE, 8'h2A);
        wr_reg(16'h1234, 8'hFF);
        rd_reg(16'h1234, rd);
        chk(rd, 8'h00, "unmapped read");
        // Every source code except RC; bits 7 and 6 are written high and must not stick
        for (int k = 0; k < 5; k++) begin
            do_switch(ADDR_CTRL, 8'hC0 | {5'h00, codes[k]},
                      (codes[k] == OSC_EXT || codes[k] == OSC_WDO) ? (SHORT_WAKE_TICKS - 1) * periods[k]
                      : (XTAL_WAKE_TICKS - 1) * 2 + XTAL_EXTRA_CYCLES, codes[k]);
            rd_reg(ADDR_CTRL, rd);
            chk(rd, 8'h80 | {5'h00, codes[k]}, "control readback");
            chk({7'h00, rc_doubler_on}, 8'h00, "doubler off");
        end
        // Fast RC select by read-modify-write of the tuning register
        rd_reg(ADDR_TUNE, rd);
        do_switch(ADDR_TUNE, rd | 8'h80, RC_CNT, OSC_RC);
        rd_reg(ADDR_TUNE, rd);
        chk(rd, 8'hAA, "trim kept by fast select");
        // Clock output at half the CPU clock while no crystal is used
        wr_reg(ADDR_TUNE, rd | 8'h40);
        repeat (3) @(negedge clk_sys);
        chk({6'h00, clock_output_active, crystal_output_pin_oe_n}, 8'h02, "clock output on");
        n = 0;
        last = crystal_output_pin_out;
        repeat (40) begin
            @(negedge clk_sys);
            if (crystal_output_pin_out !== last) n++;
            last = crystal_output_pin_out;
        end
        chk(8'(n), 8'h0A, "clock output toggles");
        // Tuning value reaches the oscillator
        wr_reg(ADDR_TUNE, 8'hFF);
        repeat (2) @(negedge clk_sys);
        chk({2'h0, rc_trim}, 8'h3F, "trim output slowest");
        // Crystal for watchdog forbids clock output
        wr_reg(ADDR_CTRL, 8'h14);
        repeat (3) @(negedge clk_sys);
        chk({6'h00, watchdog_clock_source}, {6'h00, WDSRC_XTAL}, "crystal watchdog clock");
        chk({7'h00, clock_output_active}, 8'h00, "clock output off with crystal");
        watchdog_clock_select = 1'b1;
        wr_reg(ADDR_CTRL, 8'h04);
        repeat (3) @(negedge clk_sys);
        chk({6'h00, watchdog_clock_source}, {6'h00, WDSRC_400K}, "fast watchdog oscillator");
        wr_reg(ADDR_CTRL, 8'h24);
        repeat (3) @(negedge clk_sys);
        chk({6'h00, watchdog_clock_source}, {6'h00, WDSRC_25K}, "slow watchdog oscillator");
        chk({7'h00, wdo_rate_slow}, 8'h01, "rate output");
        watchdog_clock_select = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk({6'h00, watchdog_clock_source}, {6'h00, WDSRC_PCLK}, "peripheral watchdog clock");
        // Doubler change alone starts a switch of the RC source
        do_switch(ADDR_CTRL, 8'h0C, RC_CNT, OSC_RC);
        chk({7'h00, rc_doubler_on}, 8'h01, "doubler on");
        conclude();
    end
endmodule
